// [ics_pkg.sv]
package ics_pkg;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_QUARTER_NS = 2500;
    localparam int SCL_QUARTER_CYC = SCL_QUARTER_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_US = 500;
    localparam int TIMEOUT_CYC = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;

    // ********************************************************
    // status byte fields
    // ********************************************************
    localparam int ST_PENDING_BIT = 7;
    localparam int ST_TIMEOUT_BIT = 6;
    localparam int ST_STOP_SEEN_BIT = 5;
    localparam int ST_MISPLACED_BIT = 4;
    localparam int ST_ACK_BIT = 3;
    localparam int ST_ADDRESSED_BIT = 2;
    localparam int ST_ARB_LOST_BIT = 1;
    localparam int ST_BUS_IDLE_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h01;

    // ********************************************************
    // fifo and command defaults
    // ********************************************************
    localparam int RESP_FIFO_DEPTH = 4;
    localparam int RETRY_W = 4;

    typedef enum logic [2:0] {
        OP_ADDRESS_PHASE = 3'h0,
        OP_BYTE_WRITE = 3'h1,
        OP_BYTE_READ = 3'h2,
        OP_STOP = 3'h3,
        OP_REPEATED_START = 3'h4
    } ics_op_t;

    typedef struct packed {
        ics_op_t op;
        logic [7:0] byte_val;
        logic ack_disable_flag;
        logic [RETRY_W-1:0] address_retry_count;
    } ics_cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] data;
    } ics_resp_t;

endpackage

// [ics_fifo.sv]
`timescale 1ns/10ps
module ics_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic [AW:0] fill;
    logic push;
    logic pop;

    // ********************************************************
    // occupancy
    // ********************************************************
    // extra pointer bit keeps full and empty apart
    assign fill = wr_ptr_ff - rd_ptr_ff;
    assign in_ready = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

    // storage, written only on push
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                if (wr_ptr_ff[AW-1:0] == AW'(DEPTH-1)) begin
                    wr_ptr_ff <= {~wr_ptr_ff[AW], {AW{1'b0}}};
                end else begin
                    wr_ptr_ff <= wr_ptr_ff + 1'b1;
                end
            end
            if (pop) begin
                if (rd_ptr_ff[AW-1:0] == AW'(DEPTH-1)) begin
                    rd_ptr_ff <= {~rd_ptr_ff[AW], {AW{1'b0}}};
                end else begin
                    rd_ptr_ff <= rd_ptr_ff + 1'b1;
                end
            end
        end
    end
endmodule

// [ics_sequencer.sv]
`timescale 1ns/10ps
module ics_sequencer #(
    parameter int TIMEOUT_CYC = ics_pkg::TIMEOUT_CYC,
    parameter int QUARTER_CYC = ics_pkg::SCL_QUARTER_CYC,
    parameter int FIFO_DEPTH = ics_pkg::RESP_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire ics_pkg::ics_cmd_t cmd,
    output logic resp_valid,
    input wire logic resp_ready,
    output ics_pkg::ics_resp_t resp,
    output logic [7:0] transfer_status,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    localparam int QW = $clog2(QUARTER_CYC + 1);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_WAIT_FREE = 3'h1,
        S_START = 3'h2,
        S_BIT = 3'h3,
        S_STOP = 3'h4,
        S_RESP = 3'h5
    } ics_state_t;

    ics_state_t state_ff;
    ics_pkg::ics_cmd_t cmd_ff;
    logic [1:0] phase_ff;
    logic [QW-1:0] qcnt_ff;
    logic [3:0] bitcnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] rx_ff;
    logic [ics_pkg::RETRY_W-1:0] tries_ff;
    logic tx_ff;
    logic retry_ff;
    logic scl_drive_ff;
    logic sda_drive_ff;
    logic ack_bit_ff;
    logic lost_ff;
    logic misplaced_ff;
    logic tmo_ff;
    logic [TW-1:0] tmo_cnt_ff;
    logic scl_meta_ff;
    logic scl_s_ff;
    logic sda_meta_ff;
    logic sda_s_ff;
    logic scl_prev_ff;
    logic sda_prev_ff;
    logic bus_idle_ff;
    logic [7:0] transfer_status_ff;
    logic tick;
    logic adv;
    logic start_det;
    logic stop_det;
    logic tmo_hit;
    logic err_hit;
    logic accept;
    logic fifo_in_ready;
    ics_pkg::ics_resp_t resp_word;

    // ********************************************************
    // pin synchronisers and bus monitor
    // ********************************************************
    // open drain: output level is always low, enable pulls the wire
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_drive_ff;
    assign sda_oe = sda_drive_ff;

    // two flops per pin plus a delayed copy for edge detection; the first stage feeds no logic
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            scl_meta_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_meta_ff <= scl_i;
            scl_s_ff <= scl_meta_ff;
            sda_meta_ff <= sda_i;
            sda_s_ff <= sda_meta_ff;
            scl_prev_ff <= scl_s_ff;
            sda_prev_ff <= sda_s_ff;
        end
    end

    // data edges while the clock line stays high are conditions
    assign start_det = scl_s_ff && scl_prev_ff && sda_prev_ff && !sda_s_ff;
    assign stop_det = scl_s_ff && scl_prev_ff && !sda_prev_ff && sda_s_ff;

    // bus idle flag follows any master, not just this one
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bus_idle_ff <= 1'b1;
        end else if (start_det) begin
            bus_idle_ff <= 1'b0;
        end else if (stop_det) begin
            bus_idle_ff <= 1'b1;
        end
    end

    // ********************************************************
    // bit timing
    // ********************************************************
    // a released clock held low by a slave stalls the phase (stretching)
    assign tick = (qcnt_ff == QW'(QUARTER_CYC - 1));
    assign adv = tick && (scl_drive_ff || scl_s_ff);

    // quarter period counter, parked while idle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            qcnt_ff <= '0;
        end else if (state_ff == S_IDLE || state_ff == S_WAIT_FREE) begin
            qcnt_ff <= '0;
        end else if (tick) begin
            if (adv) begin
                qcnt_ff <= '0;
            end
        end else begin
            qcnt_ff <= qcnt_ff + 1'b1;
        end
    end

    // ********************************************************
    // timeout and fault detection
    // ********************************************************
    // counts from acceptance; a stuck bus or long stretch ends the command
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tmo_cnt_ff <= '0;
        end else if (state_ff == S_IDLE || state_ff == S_RESP) begin
            tmo_cnt_ff <= '0;
        end else if (!tmo_hit) begin
            tmo_cnt_ff <= tmo_cnt_ff + 1'b1;
        end
    end

    assign tmo_hit = (tmo_cnt_ff == TW'(TIMEOUT_CYC - 1));
    assign err_hit = (state_ff == S_BIT) && (start_det || stop_det);
    assign accept = cmd_valid && cmd_ready;
    assign cmd_ready = (state_ff == S_IDLE);

    // ********************************************************
    // command sequencer
    // ********************************************************
    // faults release both lines at once so the bus is left free
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_ff <= S_IDLE;
            cmd_ff <= '0;
            phase_ff <= 2'h0;
            bitcnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            rx_ff <= 8'h00;
            tries_ff <= '0;
            tx_ff <= 1'b0;
            retry_ff <= 1'b0;
            scl_drive_ff <= 1'b0;
            sda_drive_ff <= 1'b0;
            ack_bit_ff <= 1'b0;
            lost_ff <= 1'b0;
            misplaced_ff <= 1'b0;
            tmo_ff <= 1'b0;
        end else if ((tmo_hit || err_hit) && state_ff != S_RESP && state_ff != S_IDLE) begin
            tmo_ff <= tmo_ff | tmo_hit;
            misplaced_ff <= misplaced_ff | err_hit;
            scl_drive_ff <= 1'b0;
            sda_drive_ff <= 1'b0;
            state_ff <= S_RESP;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    if (accept) begin
                        cmd_ff <= cmd;
                        phase_ff <= 2'h0;
                        bitcnt_ff <= 4'h0;
                        retry_ff <= 1'b0;
                        lost_ff <= 1'b0;
                        misplaced_ff <= 1'b0;
                        tmo_ff <= 1'b0;
                        // a count of zero still makes one attempt
                        tries_ff <= (cmd.address_retry_count == '0) ? 
                            ics_pkg::RETRY_W'(1) : cmd.address_retry_count;
                        shift_ff <= cmd.byte_val;
                        case (cmd.op)
                            ics_pkg::OP_ADDRESS_PHASE: begin
                                state_ff <= S_WAIT_FREE;
                            end
                            ics_pkg::OP_REPEATED_START: begin
                                state_ff <= S_START;
                            end
                            ics_pkg::OP_BYTE_WRITE: begin
                                tx_ff <= 1'b1;
                                state_ff <= S_BIT;
                            end
                            ics_pkg::OP_BYTE_READ: begin
                                tx_ff <= 1'b0;
                                state_ff <= S_BIT;
                            end
                            ics_pkg::OP_STOP: begin
                                state_ff <= S_STOP;
                            end
                            default: begin
                                state_ff <= S_RESP;
                            end
                        endcase
                    end
                end
                S_WAIT_FREE: begin
                    if (bus_idle_ff) begin
                        phase_ff <= 2'h0;
                        state_ff <= S_START;
                    end
                end
                S_START: begin
                    // release data, release clock, data low, clock low;
                    // from an owned bus this is a repeated start, no stop
                    if (adv) begin
                        phase_ff <= phase_ff + 2'h1;
                        case (phase_ff)
                            2'h0: sda_drive_ff <= 1'b0;
                            2'h1: scl_drive_ff <= 1'b0;
                            2'h2: sda_drive_ff <= 1'b1;
                            default: begin
                                scl_drive_ff <= 1'b1;
                                shift_ff <= cmd_ff.byte_val;
                                tx_ff <= 1'b1;
                                bitcnt_ff <= 4'h0;
                                state_ff <= S_BIT;
                            end
                        endcase
                    end
                end
                S_BIT: begin
                    if (adv) begin
                        phase_ff <= phase_ff + 2'h1;
                        case (phase_ff)
                            2'h0: begin
                                if (bitcnt_ff != 4'h8) begin
                                    sda_drive_ff <= tx_ff && !shift_ff[7];
                                end else begin
                                    sda_drive_ff <= !tx_ff && !cmd_ff.ack_disable_flag;
                                end
                            end
                            2'h1: scl_drive_ff <= 1'b0;
                            2'h2: begin
                                if (bitcnt_ff != 4'h8) begin
                                    rx_ff <= {rx_ff[6:0], sda_s_ff};
                                    shift_ff <= {shift_ff[6:0], 1'b0};
                                    if (tx_ff && shift_ff[7] && !sda_s_ff) begin
                                        // another master pulled a released one low
                                        lost_ff <= 1'b1;
                                        sda_drive_ff <= 1'b0;
                                        state_ff <= S_RESP;
                                    end
                                end else if (tx_ff) begin
                                    ack_bit_ff <= sda_s_ff;
                                end else begin
                                    ack_bit_ff <= cmd_ff.ack_disable_flag;
                                end
                            end
                            default: begin
                                scl_drive_ff <= 1'b1;
                                if (bitcnt_ff == 4'h8) begin
                                    sda_drive_ff <= 1'b0;
                                    if ((cmd_ff.op == ics_pkg::OP_ADDRESS_PHASE ||
                                         cmd_ff.op == ics_pkg::OP_REPEATED_START) &&
                                        ack_bit_ff && tries_ff > ics_pkg::RETRY_W'(1)) begin
                                        tries_ff <= tries_ff - 1'b1;
                                        retry_ff <= 1'b1;
                                        state_ff <= S_STOP;
                                    end else begin
                                        state_ff <= S_RESP;
                                    end
                                end else begin
                                    bitcnt_ff <= bitcnt_ff + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                S_STOP: begin
                    // clock low with data low, release clock, release data
                    if (adv) begin
                        phase_ff <= phase_ff + 2'h1;
                        case (phase_ff)
                            2'h0: begin
                                scl_drive_ff <= 1'b1;
                                sda_drive_ff <= 1'b1;
                            end
                            2'h1: scl_drive_ff <= 1'b0;
                            2'h2: sda_drive_ff <= 1'b0;
                            default: begin
                                if (retry_ff) begin
                                    retry_ff <= 1'b0;
                                    state_ff <= S_WAIT_FREE;
                                end else begin
                                    state_ff <= S_RESP;
                                end
                            end
                        endcase
                    end
                end
                S_RESP: begin
                    // a full answer queue stalls the sequencer here
                    if (fifo_in_ready) begin
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // status byte and answer queue
    // ********************************************************
    // answer word: status with pending clear, plus the received byte
    always_comb begin
        resp_word.status = 8'h00;
        resp_word.status[ics_pkg::ST_PENDING_BIT] = 1'b0;
        resp_word.status[ics_pkg::ST_TIMEOUT_BIT] = tmo_ff;
        resp_word.status[ics_pkg::ST_STOP_SEEN_BIT] = 1'b0;
        resp_word.status[ics_pkg::ST_MISPLACED_BIT] = misplaced_ff;
        resp_word.status[ics_pkg::ST_ACK_BIT] = ack_bit_ff;
        resp_word.status[ics_pkg::ST_ADDRESSED_BIT] = 1'b0;
        resp_word.status[ics_pkg::ST_ARB_LOST_BIT] = lost_ff;
        resp_word.status[ics_pkg::ST_BUS_IDLE_BIT] = bus_idle_ff;
        resp_word.data = rx_ff;
    end

    // live copy, pending high while any command is in flight
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            transfer_status_ff <= ics_pkg::STATUS_RESET;
        end else begin
            transfer_status_ff <= resp_word.status;
            transfer_status_ff[ics_pkg::ST_PENDING_BIT] <= (state_ff != S_IDLE);
        end
    end

    assign transfer_status = transfer_status_ff;

    ics_fifo #(
        .WIDTH($bits(ics_pkg::ics_resp_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_resp_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(state_ff == S_RESP),
        .in_ready(fifo_in_ready),
        .in_data(resp_word),
        .out_valid(resp_valid),
        .out_ready(resp_ready),
        .out_data(resp)
    );
endmodule

// [ics_sva.sv]
`timescale 1ns/10ps
// ********
// port checks for the command sequencer
// ********
module ics_sva #(
    parameter int TIMEOUT_CYC = ics_pkg::TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire ics_pkg::ics_cmd_t cmd,
    input wire logic resp_valid,
    input wire ics_pkg::ics_resp_t resp,
    input wire logic [7:0] transfer_status,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe
);
    localparam int TO_MAX = TIMEOUT_CYC + 40;
    ics_pkg::ics_op_t op_ff;
    logic nack_ff;
    int busy_ff;
    logic ans_wait_ff;
    int ans_cnt_ff;
    wire acc = cmd_valid && cmd_ready;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // last accepted command, needed to judge its answer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            op_ff <= ics_pkg::OP_STOP;
            nack_ff <= 1'b0;
        end else if (acc) begin
            op_ff <= cmd.op;
            nack_ff <= cmd.ack_disable_flag;
        end
    end
    // busy length; includes fifo waits, so it only overestimates
    always_ff @(posedge clk_sys) begin
        if (!nrst || cmd_ready) begin
            busy_ff <= 0;
        end else begin
            busy_ff <= busy_ff + 1;
        end
    end
    property p_zero5; !transfer_status[5] && !(resp_valid && resp.status[5]); endproperty
    a_zero5: assert property (p_zero5) else $error("bit 5 set");
    property p_zero2; !transfer_status[2] && !(resp_valid && resp.status[2]); endproperty
    a_zero2: assert property (p_zero2) else $error("bit 2 set");
    property p_pend; acc |-> ##[1:2] transfer_status[7]; endproperty
    a_pend: assert property (p_pend) else $error("pending flag low");
    property p_busy; acc |=> !cmd_ready [*8]; endproperty
    a_busy: assert property (p_busy) else $error("ready too early");
    // wait for an answer, counted: the bound is far beyond a delay range
    always_ff @(posedge clk_sys) begin
        if (!nrst || resp_valid) begin
            ans_wait_ff <= 1'b0;
            ans_cnt_ff <= 0;
        end else if (acc || ans_wait_ff) begin
            ans_wait_ff <= 1'b1;
            ans_cnt_ff <= ans_cnt_ff + 1;
        end
    end
    property p_ans; ans_cnt_ff <= TO_MAX; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_tout; $rose(transfer_status[6]) |-> busy_ff >= TIMEOUT_CYC - 4; endproperty
    a_tout: assert property (p_tout) else $error("early timeout");
    property p_rdack;
        $rose(resp_valid) && op_ff == ics_pkg::OP_BYTE_READ |-> resp.status[3] == nack_ff;
    endproperty
    a_rdack: assert property (p_rdack) else $error("read ack bit");
    property p_nack; !cmd_ready && busy_ff > 8 && nack_ff && op_ff == 3'h2 |-> !sda_oe; endproperty
    a_nack: assert property (p_nack) else $error("ack driven");
    property p_idle; $fell(sda_i) && scl_i |-> ##[1:6] !transfer_status[0]; endproperty
    a_idle: assert property (p_idle) else $error("start not seen");
endmodule
bind ics_sequencer ics_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_sva (.clk_sys(clk_sys), .nrst(nrst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid),
    .resp(resp), .transfer_status(transfer_status), .scl_i(scl_i), .sda_i(sda_i),
    .sda_oe(sda_oe));

// [ics_slave_model.sv]
`timescale 1ns/10ps
// ********
// behavioural bus slave
// ********
module ics_slave_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] tx_byte,
    output logic sda_oe,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    logic act = 1'b0;
    logic adr = 1'b0;
    logic rd = 1'b0;
    int cnt = 0;
    wire tx = rd && !adr;
    initial sda_oe = 1'b0;
    // start restarts the byte count, stop frees the line
    // judged just after the edge: a clock falling in the same step is no condition
    always @(negedge sda) begin
        #1;
        if (scl) begin
            act = 1'b1;
            adr = 1'b1;
            rd = 1'b0;
            cnt = -1;
            sda_oe = 1'b0;
        end
    end
    always @(posedge sda) begin
        #1;
        if (scl) begin
            act = 1'b0;
            sda_oe = 1'b0;
        end
    end
    // sample msb first; a declined byte ends our sending
    always @(posedge scl) if (act) begin
        if (!tx && cnt < 8) sh = {sh[6:0], sda};
        if (tx && cnt == 8 && sda) act = 1'b0;
    end
    // change data only while the clock is low
    always @(negedge scl) if (act) begin
        if (cnt == 7) begin
            cnt = 8;
            if (adr && sh[7:1] != ADDR) act = 1'b0;
            if (adr) rd = sh[0];
            if (!tx) rx_byte = sh;
            sda_oe = act && !tx;
        end else if (cnt == 8) begin
            cnt = 0;
            adr = 1'b0;
            sh = tx_byte;
            sda_oe = rd && !tx_byte[7];
        end else begin
            cnt++;
            if (tx) sh = {sh[6:0], 1'b1};
            sda_oe = tx && !sh[7];
        end
    end
endmodule

// [ics_sequencer_tb_top.sv]
`timescale 1ns/10ps
// ********
// command level bench
// ********
module ics_sequencer_tb_top;
    logic clk_sys;
    logic nrst = 1'b0;
    logic cmd_valid = 1'b0;
    logic resp_ready = 1'b0;
    logic hold = 1'b0;
    logic grab = 1'b0;
    logic cmd_ready, resp_valid, scl_oe, sda_oe, s_oe;
    logic [7:0] transfer_status, rx_byte;
    logic [7:0] tx_byte = 8'hc3;
    ics_pkg::ics_cmd_t cmd = '0;
    ics_pkg::ics_resp_t resp, rs;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_start = 0;
    int n_stop = 0;
    int n0;
    // open drain wires with pull-ups; hold forces a stuck clock
    wire scl = !((scl_oe === 1'b1) || hold);
    wire sda = !((sda_oe === 1'b1) || s_oe || grab);
    ics_sequencer #(.TIMEOUT_CYC(2000), .QUARTER_CYC(5), .FIFO_DEPTH(4)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .resp_valid(resp_valid), .resp_ready(resp_ready), .resp(resp),
        .transfer_status(transfer_status), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
    ics_slave_model #(.ADDR(7'h50)) i_slave (.scl(scl), .sda(sda), .tx_byte(tx_byte),
        .sda_oe(s_oe), .rx_byte(rx_byte));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // bus conditions counted on the wire
    always @(negedge sda) if (scl) n_start++;
    always @(posedge sda) if (scl) n_stop++;
    // watchdog, far above the expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [2:0] op, input logic [7:0] b, input logic f);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd = '{ics_pkg::ics_op_t'(op), b, f, 4'h1};
        if (op == 3'h0) cmd.address_retry_count = 4'h3;
        @(posedge clk_sys);
        while (cmd_ready !== 1'b1) @(posedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask
    task automatic get();
        @(negedge clk_sys);
        resp_ready = 1'b1;
        @(posedge clk_sys);
        while (resp_valid !== 1'b1) @(posedge clk_sys);
        rs = resp;
        @(negedge clk_sys);
        resp_ready = 1'b0;
    endtask
    task automatic run(input logic [2:0] op, input logic [7:0] b, input logic f);
        send(op, b, f);
        get();
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ops: 0 address, 1 write, 2 read, 3 stop, 4 repeated start
    initial begin
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        @(negedge clk_sys);
        chk(transfer_status, 8'h01);
        n0 = n_start;
        run(3'h0, 8'h42, 1'b0);
        chk(rs.status & 8'h7e, 8'h08);
        chk(8'(n_start - n0), 8'h03);
        run(3'h3, 8'h00, 1'b0);
        chk(rs.status & 8'h7e, 8'h08);
        chk({7'h0, transfer_status[0]}, 8'h01);
        run(3'h0, 8'ha0, 1'b0);
        chk(rs.status & 8'h7e, 8'h00);
        chk({7'h0, transfer_status[0]}, 8'h00);
        run(3'h1, 8'h5a, 1'b0);
        chk(rs.status & 8'h7e, 8'h00);
        chk(rx_byte, 8'h5a);
        n0 = n_stop;
        run(3'h4, 8'ha1, 1'b0);
        chk(8'(n_stop - n0) | (rs.status & 8'h7e), 8'h00);
        // acknowledge all but the last byte read
        for (int f = 0; f < 2; f++) begin
            run(3'h2, 8'h00, f[0]);
            chk(rs.data, 8'hc3);
            chk(rs.status & 8'h7e, {4'h0, f[0], 3'h0});
        end
        run(3'h3, 8'h00, 1'b0);
        chk({7'h0, transfer_status[0]}, 8'h01);
        hold = 1'b1;
        run(3'h0, 8'ha0, 1'b0);
        chk(rs.status & 8'h40, 8'h40);
        hold = 1'b0;
        // a foreign start inside a byte aborts it
        send(3'h1, 8'hff, 1'b0);
        repeat (8) @(negedge clk_sys);
        grab = 1'b1;
        get();
        chk(rs.status & 8'h12, 8'h10);
        grab = 1'b0;
        // let the stop settle so it does not land inside the next byte
        repeat (4) @(negedge clk_sys);
        // another master holds data low while the clock is low
        send(3'h1, 8'hff, 1'b0);
        @(negedge scl);
        @(negedge clk_sys);
        grab = 1'b1;
        get();
        chk(rs.status & 8'h12, 8'h02);
        grab = 1'b0;
        // host stalls until the answer queue refuses more
        for (int i = 0; i < 5; i++) send(3'h3, 8'h00, 1'b0);
        repeat (60) @(negedge clk_sys);
        chk({7'h0, cmd_ready}, 8'h00);
        for (int i = 0; i < 5; i++) begin
            get();
            chk(rs.status & 8'h40, 8'h00);
        end
        chk({7'h0, resp_valid}, 8'h00);
        finish_test();
    end
endmodule
